// file: inc/sral_pkg.sv
package sral_pkg;

    // ==========================================================
    // Widths and address map
    localparam int ADDR_W      = 22;
    localparam int DATA_W      = 16;
    localparam int SECT0_SHIFT = 15;
    localparam int REGION_AW   = 8;
    localparam int CUST_BIT    = 7;
    localparam int CMD_AW      = 11;

    // ==========================================================
    // Command cycles
    localparam logic [CMD_AW-1:0] UNLOCK_ADDR1  = 11'h555;
    localparam logic [CMD_AW-1:0] UNLOCK_ADDR2  = 11'h2AA;
    localparam logic [CMD_AW-1:0] EXIT_ADDR     = 11'h000;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1   = 16'h00AA;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2   = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_ENTRY     = 16'h0088;
    localparam logic [DATA_W-1:0] CMD_EXIT      = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_EXIT_DATA = 16'h0000;
    localparam logic [DATA_W-1:0] CMD_PROG      = 16'h00A0;

    // ==========================================================
    // Indicator word and read values
    localparam logic [REGION_AW-1:0] IND_ADDR      = 8'h03;
    localparam int                   FACT_LOCK_BIT = 7;
    localparam int                   CUST_LOCK_BIT = 6;
    localparam logic [DATA_W-1:0]    INVALID_DATA  = 16'hFFFF;
    localparam logic [DATA_W-1:0]    ERASED_DATA   = 16'hFFFF;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 40;
    localparam int PROG_TIME_NS = 1000;
    localparam int PROG_CYCLES  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

    // ==========================================================
    // Reset values of the pin synchroniser: ce_n, oe_n, we_n high, clk low
    localparam logic [3:0] PIN_CTRL_RST = 4'hE;

    typedef enum logic [2:0] {
        CMD_IDLE  = 3'b000,
        CMD_UNL1  = 3'b001,
        CMD_UNL2  = 3'b010,
        CMD_EXIT4 = 3'b011,
        CMD_PSET  = 3'b100
    } sral_cmd_t;

    typedef enum logic [1:0] {
        SEL_ARRAY   = 2'b00,
        SEL_REGION  = 2'b01,
        SEL_INVALID = 2'b10,
        SEL_IND     = 2'b11
    } sral_sel_t;

endpackage

// file: rtl/sral_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sral_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    // Pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } sral_sync_st_t;

    sral_sync_st_t st_q;
    sral_sync_st_t st_d;

    // ==========================================================
    // Three stages; a bit moves only when stages two and three agree
    always_comb begin
        st_d        = st_q;
        st_d.s1     = async_i;
        st_d.s2     = st_q.s1;
        st_d.s3     = st_q.s2;
        st_d.stable = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.stable);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= {4{RST_VAL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stable;

endmodule // sral_sync
`default_nettype wire

// file: rtl/sral_otp.sv
`timescale 1ns/1ps
`default_nettype none
module sral_otp
    import sral_pkg::*;
#(
    parameter int WORDS = 256,
    parameter int W     = 16,
    parameter int AW    = 8
) (
    // Clock and reset
    input  wire logic          sys_clk_i,
    input  wire logic          rst_n_i,
    // Read port
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o,
    // Program port
    input  wire logic          prog_start_i,
    input  wire logic [AW-1:0] prog_addr_i,
    input  wire logic [W-1:0]  prog_data_i,
    output logic               busy_o
);
    import sral_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    typedef struct packed {
        logic             busy;
        logic [CNT_W-1:0] cnt;
        logic [AW-1:0]    pa;
        logic [W-1:0]     pd;
        logic [W-1:0]     rd;
    } sral_otp_st_t;

    sral_otp_st_t st_q;
    sral_otp_st_t st_d;
    logic         done;

    // Stored contents survive reset; erased cells read all ones
    logic [W-1:0] mem [WORDS] = '{default: ERASED_DATA};

    always_comb begin
        st_d    = st_q;
        done    = 1'b0;
        st_d.rd = mem[rd_addr_i];
        if (st_q.busy) begin
            if (st_q.cnt == CNT_W'(1)) begin
                st_d.busy = 1'b0;
                done      = 1'b1;
            end
            st_d.cnt = st_q.cnt - CNT_W'(1);
        end else if (prog_start_i) begin
            st_d.busy = 1'b1;
            st_d.cnt  = CNT_W'(PROG_CYCLES);
            st_d.pa   = prog_addr_i;
            st_d.pd   = prog_data_i;
        end
    end

    // Reset aborts a program in flight; the cell keeps its old value
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Programming only clears bits, as in the flash cell
    always_ff @(posedge sys_clk_i) begin
        if (done) begin
            mem[st_q.pa] <= mem[st_q.pa] & st_q.pd;
        end
    end

    assign rd_data_o = st_q.rd;
    assign busy_o    = st_q.busy;

    prog_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (prog_start_i && !busy_o) |=> busy_o [*8])
        else $error("program did not hold busy");

endmodule // sral_otp
`default_nettype wire

// file: rtl/sral_top.sv
`timescale 1ns/1ps
`default_nettype none
module sral_top
    import sral_pkg::*;
(
    // Clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    // Host bus pins
    input  wire logic                        ce_n_i,
    input  wire logic                        oe_n_i,
    input  wire logic                        we_n_i,
    input  wire logic                        flash_clk_i,
    input  wire logic [sral_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [sral_pkg::DATA_W-1:0] dq_i,
    output logic      [sral_pkg::DATA_W-1:0] dq_o,
    output logic                             dq_oe_o,
    // Device context
    input  wire logic                        burst_mode_i,
    input  wire logic                        autoselect_i,
    input  wire logic                        embedded_busy_i,
    input  wire logic                        cust_lock_nv_i,
    input  wire logic [sral_pkg::DATA_W-1:0] array_rdata_i,
    // Device control
    output logic      [sral_pkg::ADDR_W-1:0] array_addr_o,
    output logic                             secure_mode_o,
    output logic                             bank0_rww_block_o,
    output logic                             acc_inhibit_o,
    output logic                             cust_prog_busy_o,
    output logic                             prog_reject_o
);
    import sral_pkg::*;

    localparam int PIN_W = 4 + ADDR_W + DATA_W;

    typedef struct packed {
        sral_cmd_t             cmd;
        logic                  secure;
        logic                  ce_n_prev;
        logic                  we_n_prev;
        logic                  fclk_prev;
        logic [REGION_AW-1:0]  boff;
        sral_sel_t             sel;
        logic                  prog_start;
        logic [REGION_AW-1:0]  prog_addr;
        logic [DATA_W-1:0]     prog_data;
        logic                  reject;
        logic [DATA_W-1:0]     dq;
        logic                  dq_oe;
        logic [ADDR_W-1:0]     arr_addr;
        logic                  bank0_block;
        logic                  acc_inh;
    } sral_top_st_t;

    sral_top_st_t          st_q;
    sral_top_st_t          st_d;
    logic [PIN_W-1:0]      pins;
    logic                  p_ce_n;
    logic                  p_oe_n;
    logic                  p_we_n;
    logic                  p_fclk;
    logic [ADDR_W-1:0]     p_addr;
    logic [DATA_W-1:0]     p_dq;
    logic [REGION_AW-1:0]  rd_off;
    logic [DATA_W-1:0]     otp_rdata;
    logic                  otp_busy;
    logic                  wr_evt;
    logic                  in_sect0;
    logic                  in_range;

    // ==========================================================
    // Helpers
    function automatic logic cyc_match(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                       input logic [CMD_AW-1:0] ea, input logic [DATA_W-1:0] ed);
        cyc_match = (a[CMD_AW-1:0] == ea) && (d == ed);
    endfunction

    function automatic logic [DATA_W-1:0] ind_word(input logic cust_locked);
        logic [DATA_W-1:0] w;
        w                = '0;
        w[FACT_LOCK_BIT] = 1'b1;
        w[CUST_LOCK_BIT] = cust_locked;
        ind_word         = w;
    endfunction

    // ==========================================================
    // Pin synchroniser
    sral_sync #(
        .W       (PIN_W),
        .RST_VAL ({PIN_CTRL_RST, {(ADDR_W + DATA_W){1'b0}}})
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({ce_n_i, oe_n_i, we_n_i, flash_clk_i, addr_i, dq_i}),
        .sync_o    (pins)
    );

    assign {p_ce_n, p_oe_n, p_we_n, p_fclk, p_addr, p_dq} = pins;

    // ==========================================================
    // Region storage
    sral_otp #(
        .WORDS (1 << REGION_AW),
        .W     (DATA_W),
        .AW    (REGION_AW)
    ) u_otp (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .rd_addr_i    (rd_off),
        .rd_data_o    (otp_rdata),
        .prog_start_i (st_q.prog_start),
        .prog_addr_i  (st_q.prog_addr),
        .prog_data_i  (st_q.prog_data),
        .busy_o       (otp_busy)
    );

    // Address and data settle in the synchroniser as long as the strobe
    assign wr_evt   = p_we_n && !st_q.we_n_prev && !p_ce_n;
    assign in_sect0 = (p_addr[ADDR_W-1:SECT0_SHIFT] == '0);
    assign in_range = (p_addr[SECT0_SHIFT-1:REGION_AW] == '0);

    // ==========================================================
    // Next state
    always_comb begin
        st_d            = st_q;
        st_d.ce_n_prev  = p_ce_n;
        st_d.we_n_prev  = p_we_n;
        st_d.fclk_prev  = p_fclk;
        st_d.prog_start = 1'b0;
        st_d.reject     = 1'b0;
        st_d.arr_addr   = p_addr;

        // burst offset loads at chip select, wraps FFh to 00h
        if (st_q.ce_n_prev && !p_ce_n) begin
            st_d.boff = p_addr[REGION_AW-1:0];
        end else if (p_fclk && !st_q.fclk_prev && !p_ce_n) begin
            st_d.boff = st_q.boff + REGION_AW'(1);
        end
        rd_off = burst_mode_i ? st_d.boff : p_addr[REGION_AW-1:0];

        if (autoselect_i && p_addr[REGION_AW-1:0] == IND_ADDR) begin
            st_d.sel = SEL_IND;
        end else if (st_q.secure && in_sect0) begin
            if (!in_range || embedded_busy_i) begin
                st_d.sel = SEL_INVALID;
            end else begin
                st_d.sel = SEL_REGION;
            end
        end else begin
            st_d.sel = SEL_ARRAY;
        end

        if (wr_evt) begin
            case (st_q.cmd)
                CMD_IDLE: begin
                    if (cyc_match(p_addr, p_dq, UNLOCK_ADDR1, CMD_UNLOCK1)) begin
                        st_d.cmd = CMD_UNL1;
                    end else if (st_q.secure && p_dq == CMD_PROG) begin
                        st_d.cmd = CMD_PSET;
                    end
                end
                CMD_UNL1: begin
                    if (cyc_match(p_addr, p_dq, UNLOCK_ADDR2, CMD_UNLOCK2)) begin
                        st_d.cmd = CMD_UNL2;
                    end else begin
                        st_d.cmd = CMD_IDLE;
                    end
                end
                CMD_UNL2: begin
                    st_d.cmd = CMD_IDLE;
                    // entry on third write, not while busy
                    if (cyc_match(p_addr, p_dq, UNLOCK_ADDR1, CMD_ENTRY) && !embedded_busy_i) begin
                        st_d.secure = 1'b1;
                    end else if (st_q.secure && cyc_match(p_addr, p_dq, UNLOCK_ADDR1, CMD_EXIT)) begin
                        st_d.cmd = CMD_EXIT4;
                    end
                end
                CMD_EXIT4: begin
                    st_d.cmd = CMD_IDLE;
                    // leave on fourth write; only this and reset clear the overlay
                    if (cyc_match(p_addr, p_dq, EXIT_ADDR, CMD_EXIT_DATA)) begin
                        st_d.secure = 1'b0;
                    end
                end
                CMD_PSET: begin
                    st_d.cmd = CMD_IDLE;
                    if (in_sect0) begin
                        // customer half only; factory half, locked half, busy: all rejected
                        if (in_range && p_addr[CUST_BIT] && !cust_lock_nv_i && !otp_busy && !embedded_busy_i) begin
                            st_d.prog_start = 1'b1;
                            st_d.prog_addr  = p_addr[REGION_AW-1:0];
                            st_d.prog_data  = p_dq;
                        end else begin
                            st_d.reject = 1'b1;
                        end
                    end
                end
                default: begin
                    st_d.cmd = CMD_IDLE;
                end
            endcase
        end

        case (st_q.sel)
            SEL_REGION:  st_d.dq = otp_rdata;
            SEL_INVALID: st_d.dq = INVALID_DATA;
            SEL_IND:     st_d.dq = ind_word(cust_lock_nv_i);
            default:     st_d.dq = array_rdata_i;
        endcase

        // output disable wins over any read
        st_d.dq_oe       = !p_oe_n && !p_ce_n && p_we_n;
        // bank 0 excluded from simultaneous operation
        st_d.bank0_block = st_d.secure;
        // fast program path blocked while the customer half programs
        // Start pulse bridges the cycle before storage busy rises
        st_d.acc_inh     = otp_busy || st_d.prog_start || st_q.prog_start;
    end

    // ==========================================================
    // State register
    // overlay cleared at reset
    // reset tristates and returns to array read
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q           <= '0;
            st_q.cmd       <= CMD_IDLE;
            st_q.sel       <= SEL_ARRAY;
            st_q.ce_n_prev <= 1'b1;
            st_q.we_n_prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign dq_o              = st_q.dq;
    assign dq_oe_o           = st_q.dq_oe;
    assign array_addr_o      = st_q.arr_addr;
    assign secure_mode_o     = st_q.secure;
    assign bank0_rww_block_o = st_q.bank0_block;
    assign acc_inhibit_o     = st_q.acc_inh;
    assign cust_prog_busy_o  = otp_busy;
    assign prog_reject_o     = st_q.reject;

    // ==========================================================
    // Checks
    oe_release_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        p_oe_n |=> !dq_oe_o)
        else $error("outputs driven while output disable high");

    entry_seq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_evt && st_q.cmd == CMD_UNL2 && !embedded_busy_i
         && cyc_match(p_addr, p_dq, UNLOCK_ADDR1, CMD_ENTRY)) |=> secure_mode_o)
        else $error("entry sequence did not map region");

    exit_seq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_evt && st_q.cmd == CMD_EXIT4 && cyc_match(p_addr, p_dq, EXIT_ADDR, CMD_EXIT_DATA))
        |=> !secure_mode_o)
        else $error("exit sequence did not unmap region");

    mode_persist_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (secure_mode_o && !(wr_evt && st_q.cmd == CMD_EXIT4)) |=> secure_mode_o)
        else $error("region mode lost without exit");

    busy_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (embedded_busy_i && !secure_mode_o) |=> !secure_mode_o)
        else $error("region entered while embedded busy");

    seq_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_evt && st_q.cmd == CMD_UNL1 && !cyc_match(p_addr, p_dq, UNLOCK_ADDR2, CMD_UNLOCK2))
        |=> (st_q.cmd == CMD_IDLE && secure_mode_o == $past(secure_mode_o)))
        else $error("bad cycle did not drop sequence");

    lock_reject_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_evt && st_q.cmd == CMD_PSET && in_sect0 && cust_lock_nv_i)
        |=> (prog_reject_o && !st_q.prog_start))
        else $error("locked customer half was programmed");

    factory_reject_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_evt && st_q.cmd == CMD_PSET && in_sect0 && !p_addr[CUST_BIT])
        |=> (prog_reject_o && !st_q.prog_start))
        else $error("factory half program not rejected");

    range_invalid_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_q.secure && in_sect0 && !in_range && !autoselect_i) |=> (st_q.sel == SEL_INVALID))
        else $error("read past region not marked invalid");

    ind_word_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (st_q.sel == SEL_IND) |=> (dq_o[FACT_LOCK_BIT] && dq_o[CUST_LOCK_BIT] == $past(cust_lock_nv_i)))
        else $error("indicator word wrong");

    burst_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (p_fclk && !st_q.fclk_prev && !p_ce_n && !st_q.ce_n_prev && st_q.boff == 8'hFF)
        |=> (st_q.boff == 8'h00))
        else $error("burst offset did not wrap");

    sect_map_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!in_sect0 && !autoselect_i) |=> (st_q.sel == SEL_ARRAY))
        else $error("sector outside 0 redirected");

    bank0_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ##1 (bank0_rww_block_o == secure_mode_o))
        else $error("bank 0 block out of step with mode");

    acc_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_q.prog_start |-> acc_inhibit_o ##1 acc_inhibit_o)
        else $error("fast program pin not blocked");

endmodule // sral_top
`default_nettype wire

// file: testbench/sral_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sral_host_model (
    // Clock and answers
    input  wire logic                        sys_clk_i,
    input  wire logic [sral_pkg::DATA_W-1:0] rd_i,
    input  wire logic                        rd_oe_i,
    // Bus pins
    output logic                             ce_n_o,
    output logic                             oe_n_o,
    output logic                             we_n_o,
    output logic                             fclk_o,
    output logic      [sral_pkg::ADDR_W-1:0] addr_o,
    output logic      [sral_pkg::DATA_W-1:0] dq_o
);
    import sral_pkg::*;
    initial begin
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        fclk_o = 1'b0;
        addr_o = '0;
        dq_o   = 16'hFFFF;
    end
    // ==========================================================
    // Bus cycles
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Released data lines flip so a stale word never reads as fresh
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr_o = a;
        dq_o   = d;
        ce_n_o = 1'b0;
        step(2);
        we_n_o = 1'b0;
        step(6);
        we_n_o = 1'b1;
        step(6);
        ce_n_o = 1'b1;
        dq_o   = ~d;
        step(8);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
        addr_o = a;
        ce_n_o = 1'b0;
        oe_n_o = 1'b0;
        step(10);
        d      = rd_i;
        oe     = rd_oe_i;
        oe_n_o = 1'b1;
        ce_n_o = 1'b1;
        step(4);
    endtask
    task automatic bst_open(input logic [ADDR_W-1:0] a);
        addr_o = a;
        ce_n_o = 1'b0;
        oe_n_o = 1'b0;
        step(10);
    endtask
    task automatic bst_next();
        fclk_o = 1'b1;
        step(6);
        fclk_o = 1'b0;
        step(6);
    endtask
    // ==========================================================
    // Command sequences
    // entry writes
    task automatic enter();
        wr(ADDR_W'(UNLOCK_ADDR1), CMD_UNLOCK1);
        wr(ADDR_W'(UNLOCK_ADDR2), CMD_UNLOCK2);
        wr(ADDR_W'(UNLOCK_ADDR1), CMD_ENTRY);
    endtask
    task automatic leave(input logic [DATA_W-1:0] last);
        wr(ADDR_W'(UNLOCK_ADDR1), CMD_UNLOCK1);
        wr(ADDR_W'(UNLOCK_ADDR2), CMD_UNLOCK2);
        wr(ADDR_W'(UNLOCK_ADDR1), CMD_EXIT);
        wr(ADDR_W'(EXIT_ADDR), last);
    endtask
    task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wr('0, CMD_PROG);
        wr(a, d);
    endtask
endmodule // sral_host_model
`default_nettype wire

// file: testbench/sral_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sral_top_bench;
    import sral_pkg::*;
    // ==========================================================
    // Signals
    logic              sys_clk = 1'b0;
    logic              rst_n   = 1'b0;
    logic              ce_n, oe_n, we_n, fclk, dq_oe, smode, b0, acc, pbusy, rej, oe_s;
    logic              burst = 1'b0, autos = 1'b0, ebusy = 1'b0, lock = 1'b0;
    logic [ADDR_W-1:0] addr, aaddr, a;
    logic [DATA_W-1:0] dq_in, dq_out, ardata, v1, v2;
    logic [DATA_W-1:0] bx [3];
    logic [31:0]       seed = 32'h00000012;
    int                n_errors = 0, samples_checked = 0, n_rej = 0;
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [DATA_W-1:0] arr(input logic [ADDR_W-1:0] x);
        return x[15:0] ^ 16'h5A5A;
    endfunction
    assign ardata = arr(aaddr);
    always @(posedge sys_clk) if (rej === 1'b1) n_rej++;
    sral_top uut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .flash_clk_i(fclk), .addr_i(addr), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe),
        .burst_mode_i(burst), .autoselect_i(autos), .embedded_busy_i(ebusy),
        .cust_lock_nv_i(lock), .array_rdata_i(ardata), .array_addr_o(aaddr), .secure_mode_o(smode),
        .bank0_rww_block_o(b0), .acc_inhibit_o(acc), .cust_prog_busy_o(pbusy), .prog_reject_o(rej)
    );
    sral_host_model host (
        .sys_clk_i(sys_clk), .rd_i(dq_out), .rd_oe_i(dq_oe), .ce_n_o(ce_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .fclk_o(fclk), .addr_o(addr), .dq_o(dq_in)
    );
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        logic              oe;
        host.rd(x, d, oe);
        check(d, e);
        check(16'(oe), 16'h0001);
        repeat (3) @(posedge sys_clk);
        #1;
        check(16'(dq_oe), 16'h0000);
    endtask
    // Waits out the program time, bounded so a stuck flag ends the run
    task automatic prog(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] d);
        int n;
        host.prog(x, d);
        check(16'(acc), 16'h0001);
        check(16'(pbusy), 16'h0001);
        n = 0;
        while (pbusy !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            end_of_test();
        end
        @(posedge sys_clk);
        #1;
        check(16'(acc), 16'h0000);
    endtask
    initial begin
        #2500000;
        n_errors++;
        end_of_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(16'(smode), 16'h0000);
        check(16'(dq_oe), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            a = ADDR_W'(rnd()) | 22'h008000;
            rdchk(a, arr(a));
        end
        host.wr(ADDR_W'(UNLOCK_ADDR1), CMD_UNLOCK1);
        host.wr(ADDR_W'(UNLOCK_ADDR2), 16'h0066);
        host.wr(ADDR_W'(UNLOCK_ADDR1), CMD_ENTRY);
        check(16'(smode), 16'h0000);
        ebusy = 1'b1;
        host.enter();
        check(16'(smode), 16'h0000);
        ebusy = 1'b0;
        host.enter();
        check(16'(smode), 16'h0001);
        check(16'(b0), 16'h0001);
        rdchk(22'h000000, ERASED_DATA);
        rdchk(22'h000100, INVALID_DATA);
        a = ADDR_W'(rnd()) | 22'h200000;
        rdchk(a, arr(a));
        v1 = 16'(rnd());
        v2 = 16'(rnd());
        prog(22'h0000FE, v1);
        prog(22'h0000FF, v2);
        rdchk(22'h0000FE, v1);
        rdchk(22'h0000FF, v2);
        ebusy = 1'b1;
        host.prog(22'h000081, 16'h0000);
        rdchk(22'h0000FE, INVALID_DATA);
        ebusy = 1'b0;
        rdchk(22'h000081, ERASED_DATA);
        host.prog(22'h000010, 16'h0000);
        rdchk(22'h000010, ERASED_DATA);
        autos = 1'b1;
        rdchk(ADDR_W'(IND_ADDR), 16'h0080);
        lock = 1'b1;
        rdchk(ADDR_W'(IND_ADDR), 16'h00C0);
        autos = 1'b0;
        host.prog(22'h0000FE, 16'h0000);
        rdchk(22'h0000FE, v1);
        check(16'(n_rej), 16'h0003);
        burst = 1'b1;
        bx = '{v1, v2, ERASED_DATA};
        host.bst_open(22'h0000FE);
        for (int i = 0; i < 3; i++) begin
            check(dq_out, bx[i]);
            host.bst_next();
        end
        host.rd(22'h0000FE, v2, oe_s);
        check(v2, ERASED_DATA);
        burst = 1'b0;
        host.wr('0, 16'h00F0);
        check(16'(smode), 16'h0001);
        host.leave(16'h1234);
        check(16'(smode), 16'h0001);
        host.leave(CMD_EXIT_DATA);
        check(16'(smode), 16'h0000);
        check(16'(b0), 16'h0000);
        rdchk(22'h0000FE, arr(22'h0000FE));
        host.enter();
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check(16'(smode), 16'h0000);
        rst_n = 1'b1;
        rdchk(22'h000010, arr(22'h000010));
        end_of_test();
    end
endmodule // sral_top_bench
`default_nettype wire
